// ### bit_rate_counter.sv
// Reloadable down counter stepping on two phases per instruction cycle.
// Assumes i_clk is the oscillator clock, four periods per cycle.
`timescale 1ns/1ps
`default_nettype none
module bit_rate_counter (
  input wire logic i_clk,
  input wire logic i_reset,
  bit_rate_if.counter rate
);
  logic [1:0] phase;
  logic [i2c_master_pkg::RATE_W-1:0] count;

  assign rate.tick = (phase == i2c_master_pkg::PHASE_Q2) ||
                     (phase == i2c_master_pkg::PHASE_Q4);
  assign rate.zero = (count == '0);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      phase <= i2c_master_pkg::PHASE_RST;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Count down to zero, then hold until reloaded
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      count <= i2c_master_pkg::RATE_RST;
    end else if (rate.load) begin
      count <= rate.reload;
    end else if (rate.tick && !rate.zero) begin
      count <= count - 1'b1;
    end
  end
endmodule : bit_rate_counter
`default_nettype wire

// ### bit_rate_if.sv
// Connection between the bus engine and its bit-rate counter.
// Assumes both ends sit in the link clock domain.
`timescale 1ns/1ps
`default_nettype none
interface bit_rate_if;
  logic load;
  logic [i2c_master_pkg::RATE_W-1:0] reload;
  logic tick;
  logic zero;
  modport engine (output load, output reload, input tick, input zero);
  modport counter (input load, input reload, output tick, output zero);
endinterface : bit_rate_if
`default_nettype wire

// ### i2c_master_pkg.sv
// Shared constants and types for the two-wire master engine.
// Assumes the link clock drives the bit-rate counter phases.
`default_nettype none
package i2c_master_pkg;
  localparam int RATE_W = 7;
  localparam logic [6:0] RATE_RST = 7'h00;
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [3:0] BITCNT_RST = 4'h0;
  localparam logic [3:0] ACK_BIT_INDEX = 4'h8;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int CTRL_START = 0;
  localparam int CTRL_RESTART = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_RECV = 3;
  localparam int CTRL_WRITE = 4;
  localparam int CTRL_ACKOUT = 5;
  localparam int CTRL_ACKSTAT = 6;
  localparam int CTRL_COLLIDE = 7;
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_START,
    CMD_RESTART,
    CMD_STOP,
    CMD_WRITE,
    CMD_READ
  } cmd_t;
endpackage : i2c_master_pkg
`default_nettype wire

// ### i2c_master_with_bit_rate_counter.sv
// Two-wire bus master engine with bit-rate counter.
// Assumes control ports on i_clk; bus logic on i_link_clk (oscillator).
// Assumes open-drain pads outside: oe_n low pulls the line low.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_with_bit_rate_counter (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_link_clk,
  input wire logic i_start_request_bit,
  input wire logic i_restart_request,
  input wire logic i_stop_request_bit,
  input wire logic i_receive_request,
  input wire logic i_ack_value,
  input wire logic i_buf_write,
  input wire logic [7:0] i_buf_wdata,
  input wire logic [6:0] i_address_reload_reg,
  input wire logic i_irq_clear,
  output logic [7:0] o_serial_control_two,
  output logic [7:0] o_shift_buffer,
  output logic o_port_irq_flag,
  output logic o_busy,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe_n,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n
);
  typedef enum logic [3:0] {
    L_IDLE,
    L_START_SU,
    L_START_HD,
    L_RS_SDA,
    L_STOP_LO,
    L_STOP_SCL,
    L_STOP_SDA,
    L_BIT_LO,
    L_BIT_HI,
    L_FINISH
  } link_state_t;

  i2c_master_pkg::cmd_t cmd_hold, next_cmd;
  logic [7:0] wdata_hold, next_ctrl, shreg;
  logic [6:0] reload_hold;
  logic [3:0] bitcnt;
  logic [1:0] pins_s;
  link_state_t state, next_state;
  logic ack_out_hold, req_tgl, busy, done_seen, done_tgl_s, done_evt, any_req, accept;
  logic ack_status, collide, scl_rel, sda_rel, next_scl_rel, next_sda_rel, req_s, req_seen;
  logic new_req, take, advance, step, scl_s, sda_s, is_ack_bit, reading, bit_level;
  logic sda_cap, seen_high, ack_rx, done_tgl;
  bit_rate_if rate ();
  // Command priority while idle; one operation at a time
  assign any_req = i_start_request_bit | i_restart_request | i_stop_request_bit |
                   i_receive_request | i_buf_write;
  assign accept = any_req && !busy;
  assign next_cmd = i_start_request_bit ? i2c_master_pkg::CMD_START :
                    i_restart_request ? i2c_master_pkg::CMD_RESTART :
                    i_stop_request_bit ? i2c_master_pkg::CMD_STOP :
                    i_receive_request ? i2c_master_pkg::CMD_READ :
                    i_buf_write ? i2c_master_pkg::CMD_WRITE : i2c_master_pkg::CMD_NONE;
  assign done_evt = done_tgl_s ^ done_seen;
  assign o_busy = busy;
  sync_two_ff #(.WIDTH(1)) u_done_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(done_tgl),
    .o_sync(done_tgl_s)
  );
  // Request fields stay stable until the link answers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cmd_hold <= i2c_master_pkg::CMD_NONE;
      wdata_hold <= i2c_master_pkg::BYTE_RST;
      reload_hold <= i2c_master_pkg::RATE_RST;
      ack_out_hold <= 1'b0;
      req_tgl <= 1'b0;
    end else if (accept) begin
      cmd_hold <= next_cmd;
      wdata_hold <= i_buf_wdata;
      reload_hold <= i_address_reload_reg;
      ack_out_hold <= i_ack_value;
      req_tgl <= ~req_tgl;
    end
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      busy <= 1'b0;
      done_seen <= 1'b0;
    end else begin
      done_seen <= done_tgl_s;
      if (accept) begin
        busy <= 1'b1;
      end else if (done_evt) begin
        busy <= 1'b0;
      end
    end
  end
  // Flag set at end of every operation; a set beats a same-cycle clear
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_port_irq_flag <= 1'b0;
    end else if (done_evt) begin
      o_port_irq_flag <= 1'b1;
    end else if (i_irq_clear) begin
      o_port_irq_flag <= 1'b0;
    end
  end
  // Buffer write while an operation runs is dropped and flagged
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      collide <= 1'b0;
    end else if (i_buf_write && busy) begin
      collide <= 1'b1;
    end else if (i_irq_clear) begin
      collide <= 1'b0;
    end
  end
  // Link results are stable once the done toggle arrives
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ack_status <= 1'b0;
      o_shift_buffer <= i2c_master_pkg::BYTE_RST;
    end else if (done_evt) begin
      if (cmd_hold == i2c_master_pkg::CMD_WRITE) begin
        ack_status <= ack_rx;
      end
      if (cmd_hold == i2c_master_pkg::CMD_READ) begin
        o_shift_buffer <= shreg;
      end
    end
  end
  always_comb begin
    next_ctrl = 8'h00;
    next_ctrl[i2c_master_pkg::CTRL_START] = busy && (cmd_hold == i2c_master_pkg::CMD_START);
    next_ctrl[i2c_master_pkg::CTRL_RESTART] = busy && (cmd_hold == i2c_master_pkg::CMD_RESTART);
    next_ctrl[i2c_master_pkg::CTRL_STOP] = busy && (cmd_hold == i2c_master_pkg::CMD_STOP);
    next_ctrl[i2c_master_pkg::CTRL_RECV] = busy && (cmd_hold == i2c_master_pkg::CMD_READ);
    next_ctrl[i2c_master_pkg::CTRL_WRITE] = busy && (cmd_hold == i2c_master_pkg::CMD_WRITE);
    next_ctrl[i2c_master_pkg::CTRL_ACKOUT] = ack_out_hold;
    next_ctrl[i2c_master_pkg::CTRL_ACKSTAT] = ack_status;
    next_ctrl[i2c_master_pkg::CTRL_COLLIDE] = collide;
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_serial_control_two <= 8'h00;
    end else begin
      o_serial_control_two <= next_ctrl;
    end
  end
  // ---- Link side ----
  sync_two_ff #(.WIDTH(1)) u_req_sync (
    .i_clk(i_link_clk),
    .i_reset(i_reset),
    .i_async(req_tgl),
    .o_sync(req_s)
  );
  sync_two_ff #(.WIDTH(2)) u_pin_sync (
    .i_clk(i_link_clk),
    .i_reset(i_reset),
    .i_async({i_scl, i_sda}),
    .o_sync(pins_s)
  );
  bit_rate_counter u_rate (
    .i_clk(i_link_clk),
    .i_reset(i_reset),
    .rate(rate.counter)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  assign new_req = req_s ^ req_seen;
  assign step = rate.tick && rate.zero;
  assign reading = (cmd_hold == i2c_master_pkg::CMD_READ);
  assign is_ack_bit = (bitcnt == i2c_master_pkg::ACK_BIT_INDEX);
  // Released for slave data or slave ack; own ack level on reads
  assign bit_level = is_ack_bit ? (reading ? ack_out_hold : 1'b1) :
                     (reading ? 1'b1 : shreg[7]);
  // High phase counts only once SCL is really high (slave stretch)
  assign rate.load = take | advance | ((state == L_BIT_HI) && !scl_s);
  assign rate.reload = reload_hold;
  // Pins only ever pulled low or released
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe_n = scl_rel;
  assign o_sda_oe_n = sda_rel;
  always_comb begin
    next_state = state;
    next_scl_rel = scl_rel;
    next_sda_rel = sda_rel;
    take = 1'b0;
    advance = 1'b0;
    case (state)
      L_IDLE: begin
        if (new_req) begin
          take = 1'b1;
          case (cmd_hold)
            i2c_master_pkg::CMD_START: begin
              next_state = L_START_SU;
              next_scl_rel = 1'b1;
              next_sda_rel = 1'b1;
            end
            i2c_master_pkg::CMD_RESTART: begin
              next_state = L_RS_SDA;
              next_sda_rel = 1'b1;
            end
            i2c_master_pkg::CMD_STOP: begin
              next_state = L_STOP_LO;
              next_sda_rel = 1'b0;
            end
            i2c_master_pkg::CMD_WRITE,
            i2c_master_pkg::CMD_READ: begin
              next_state = L_BIT_LO;
            end
            default: begin
              next_state = L_FINISH;
            end
          endcase
        end
      end
      L_RS_SDA: begin
        if (step) begin
          next_state = L_START_SU;
          next_scl_rel = 1'b1;
          advance = 1'b1;
        end
      end
      L_START_SU: begin
        if (step) begin
          next_state = L_START_HD;
          next_sda_rel = 1'b0;
          advance = 1'b1;
        end
      end
      L_START_HD: begin
        if (step) begin
          next_state = L_FINISH;
          next_scl_rel = 1'b0;
          advance = 1'b1;
        end
      end
      L_STOP_LO: begin
        if (step) begin
          next_state = L_STOP_SCL;
          next_scl_rel = 1'b1;
          advance = 1'b1;
        end
      end
      L_STOP_SCL: begin
        if (step) begin
          next_state = L_STOP_SDA;
          next_sda_rel = 1'b1;
          advance = 1'b1;
        end
      end
      L_STOP_SDA: begin
        if (step) begin
          next_state = L_FINISH;
          advance = 1'b1;
        end
      end
      L_BIT_LO: begin
        next_sda_rel = bit_level;
        if (step) begin
          next_state = L_BIT_HI;
          next_scl_rel = 1'b1;
          advance = 1'b1;
        end
      end
      L_BIT_HI: begin
        if (step && scl_s) begin
          next_scl_rel = 1'b0;
          advance = 1'b1;
          next_state = is_ack_bit ? L_FINISH : L_BIT_LO;
        end
      end
      L_FINISH: begin
        next_state = L_IDLE;
      end
      default: begin
        next_state = L_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= L_IDLE;
      scl_rel <= 1'b1;
      sda_rel <= 1'b1;
    end else begin
      state <= next_state;
      scl_rel <= next_scl_rel;
      sda_rel <= next_sda_rel;
    end
  end
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      req_seen <= 1'b0;
      done_tgl <= 1'b0;
    end else begin
      if (take) begin
        req_seen <= req_s;
      end
      if (state == L_FINISH) begin
        done_tgl <= ~done_tgl;
      end
    end
  end
  // Capture SDA on the first cycle SCL is seen high
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      sda_cap <= 1'b1;
      seen_high <= 1'b0;
    end else if (state != L_BIT_HI) begin
      seen_high <= 1'b0;
    end else if (scl_s && !seen_high) begin
      sda_cap <= sda_s;
      seen_high <= 1'b1;
    end
  end
  // Shift MSB first; ninth bit is the acknowledge
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      shreg <= i2c_master_pkg::BYTE_RST;
      bitcnt <= i2c_master_pkg::BITCNT_RST;
      ack_rx <= 1'b1;
    end else if (take) begin
      bitcnt <= i2c_master_pkg::BITCNT_RST;
      if (cmd_hold == i2c_master_pkg::CMD_WRITE) begin
        shreg <= wdata_hold;
      end
    end else if ((state == L_BIT_HI) && advance) begin
      if (is_ack_bit) begin
        ack_rx <= sda_cap;
      end else begin
        shreg <= {shreg[6:0], sda_cap};
        bitcnt <= bitcnt + 4'h1;
      end
    end
  end
endmodule : i2c_master_with_bit_rate_counter
`default_nettype wire

// ### i2c_master_with_bit_rate_counter_assertions.sv
// Port checker for the two-wire master engine.
// Assumes it is bound to every engine instance.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_checker (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_link_clk,
  input wire logic i_buf_write,
  input wire logic i_irq_clear,
  input wire logic [7:0] o_serial_control_two,
  input wire logic o_port_irq_flag,
  input wire logic o_busy,
  input wire logic o_scl,
  input wire logic o_scl_oe_n,
  input wire logic o_sda,
  input wire logic o_sda_oe_n
);
  property p_accept;
    @(posedge i_clk) disable iff (i_reset) !o_busy && i_buf_write |=> o_busy;
  endproperty
  a_accept: assert property (p_accept) else $error("write not taken");
  property p_done_flag;
    @(posedge i_clk) disable iff (i_reset) $fell(o_busy) |-> o_port_irq_flag;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("no flag at done");
  property p_done_ctrl;
    @(posedge i_clk) disable iff (i_reset) $fell(o_busy) |=> o_serial_control_two[4:0] == 5'h00;
  endproperty
  a_done_ctrl: assert property (p_done_ctrl) else $error("busy bit kept");
  property p_collide;
    @(posedge i_clk) disable iff (i_reset)
      o_busy && i_buf_write && !i_irq_clear |-> ##[1:2] o_serial_control_two[7];
  endproperty
  a_collide: assert property (p_collide) else $error("refused write unseen");
  property p_flag_hold;
    @(posedge i_clk) disable iff (i_reset) o_port_irq_flag && !i_irq_clear |=> o_port_irq_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
  property p_flag_clear;
    @(posedge i_clk) disable iff (i_reset) (i_irq_clear && o_busy) ##1 o_busy |-> !o_port_irq_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
  property p_idle_pins;
    @(posedge i_clk) disable iff (i_reset)
      !o_busy && !$past(o_busy) |-> $stable({o_scl_oe_n, o_sda_oe_n});
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("pins move while idle");
  property p_low_only;
    @(posedge i_link_clk) disable iff (i_reset) o_scl == 1'b0 && o_sda == 1'b0;
  endproperty
  a_low_only: assert property (p_low_only) else $error("line driven high");
  property p_high_phase;
    @(posedge i_link_clk) disable iff (i_reset) $rose(o_scl_oe_n) |=> o_scl_oe_n [*3];
  endproperty
  a_high_phase: assert property (p_high_phase) else $error("clock high too short");
  c_flag: cover property (@(posedge i_clk) disable iff (i_reset) $rose(o_port_irq_flag));
  c_collide: cover property (@(posedge i_clk) disable iff (i_reset) $rose(o_serial_control_two[7]));
  c_nack: cover property (@(posedge i_clk) disable iff (i_reset) $rose(o_serial_control_two[6]));
endmodule : i2c_master_checker
bind i2c_master_with_bit_rate_counter i2c_master_checker i2c_master_checker_inst (
  .i_clk(i_clk), .i_reset(i_reset), .i_link_clk(i_link_clk), .i_buf_write(i_buf_write),
  .i_irq_clear(i_irq_clear), .o_serial_control_two(o_serial_control_two),
  .o_port_irq_flag(o_port_irq_flag), .o_busy(o_busy), .o_scl(o_scl),
  .o_scl_oe_n(o_scl_oe_n), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n)
);
`default_nettype wire

// ### i2c_slave_model.sv
// Behavioural two-wire slave at one address.
// Assumes wired-and lines with pull-ups in the bench.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_stretch,
  input wire logic [7:0] i_rd_byte,
  output logic o_sda_oe_n,
  output logic o_scl_oe_n,
  output logic [7:0] o_last,
  output logic o_mack
);
  logic go = 1'b0;
  logic first;
  logic rd;
  logic nak;
  logic [7:0] sh;
  initial begin
    o_sda_oe_n = 1'b1;
    o_scl_oe_n = 1'b1;
    o_last = 8'h00;
    o_mack = 1'b0;
  end
  always @(negedge i_sda) if (i_scl === 1'b1) begin
    disable frame;
    o_sda_oe_n = 1'b1;
    go = 1'b1;
  end
  always @(posedge i_sda) if (i_scl === 1'b1) begin
    disable frame;
    o_sda_oe_n = 1'b1;
  end
  always begin : frame
    wait (go);
    go = 1'b0;
    first = 1'b1;
    rd = 1'b0;
    forever begin
      if (rd) begin
        for (int i = 7; i >= 0; i--) begin
          o_sda_oe_n = i_rd_byte[i];
          @(negedge i_scl);
        end
        o_sda_oe_n = 1'b1;
        @(posedge i_scl) o_mack = i_sda;
        @(negedge i_scl);
        if (o_mack) rd = 1'b0;
      end else begin
        for (int i = 7; i >= 0; i--) @(posedge i_scl) sh[i] = i_sda;
        @(negedge i_scl);
        nak = first && sh[7:1] != ADDR;
        if (first) rd = sh[0] & !nak;
        else o_last = sh;
        o_sda_oe_n = nak;
        // Address ack clock held low past a whole low phase
        if (i_stretch && first) begin
          o_scl_oe_n = 1'b0;
          #1000 o_scl_oe_n = 1'b1;
        end
        @(negedge i_scl);
        // A read drives its first bit from this same edge
        if (!rd) o_sda_oe_n = 1'b1;
        first = 1'b0;
      end
    end
  end
endmodule : i2c_slave_model
`default_nettype wire

// ### sync_two_ff.sv
// Two flip-flop synchroniser for levels and toggles.
// Assumes inputs are quasi-static relative to the destination clock.
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule : sync_two_ff
`default_nettype wire

// ### test_i2c_master_with_bit_rate_counter.sv
// Bench for the two-wire master engine with one slave model.
// Assumes the bus is a wired-and with pull-ups made here.
`timescale 1ns/1ps
`default_nettype none
module test_i2c_master_with_bit_rate_counter;
  localparam logic [6:0] SLV = 7'h2a;
  logic clk = 1'b0, lclk = 1'b0, rst = 1'b1;
  logic start_r = 1'b0, restart_r = 1'b0, stop_r = 1'b0, recv_r = 1'b0, wr_r = 1'b0;
  logic ackv = 1'b0, clr = 1'b0, stretch = 1'b0;
  logic [7:0] wdata = 8'h00, rdb = 8'h00, ctrl, sbuf, last;
  logic [6:0] rel = 7'h02;
  logic flag, busy, mack, scl_o, sda_o, scl_oe_n, sda_oe_n, s_scl_oe_n, s_sda_oe_n;
  wire scl = scl_oe_n & s_scl_oe_n;
  wire sda = sda_oe_n & s_sda_oe_n;
  int n_fail = 0, n_tests = 0, n_start = 0, n_stop = 0;
  longint tl = 0, tp = 0;
  always #5 clk = ~clk;
  always #24 lclk = ~lclk;
  always @(negedge sda) if (scl) n_start++;
  always @(posedge sda) if (scl) n_stop++;
  always @(posedge scl) begin
    tp = tl;
    tl = $time;
  end
  i2c_master_with_bit_rate_counter i2c_master_with_bit_rate_counter_inst (
    .i_clk(clk), .i_reset(rst), .i_link_clk(lclk), .i_start_request_bit(start_r),
    .i_restart_request(restart_r), .i_stop_request_bit(stop_r), .i_receive_request(recv_r),
    .i_ack_value(ackv), .i_buf_write(wr_r), .i_buf_wdata(wdata), .i_address_reload_reg(rel),
    .i_irq_clear(clr), .o_serial_control_two(ctrl), .o_shift_buffer(sbuf),
    .o_port_irq_flag(flag), .o_busy(busy), .i_scl(scl), .o_scl(scl_o),
    .o_scl_oe_n(scl_oe_n), .i_sda(sda), .o_sda(sda_o), .o_sda_oe_n(sda_oe_n)
  );
  i2c_slave_model #(.ADDR(SLV)) i2c_slave_model_inst (
    .i_scl(scl), .i_sda(sda), .i_stretch(stretch), .i_rd_byte(rdb),
    .o_sda_oe_n(s_sda_oe_n), .o_scl_oe_n(s_scl_oe_n), .o_last(last), .o_mack(mack)
  );
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  // Codes: 0 start, 1 restart, 2 stop, 3 receive, 4 write
  task automatic op(input int k, input logic [7:0] d, input logic a, input logic dup);
    int n;
    @(negedge clk);
    {start_r, restart_r, stop_r, recv_r, wr_r} = 5'h10 >> k;
    wdata = d;
    ackv = a;
    @(negedge clk);
    {start_r, restart_r, stop_r, recv_r, wr_r} = 5'h00;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    chk(flag, 1'b0, "flag cleared");
    wr_r = dup;
    wdata = ~d;
    @(negedge clk);
    wr_r = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n == 5000) begin
      chk(busy, 1'b0, "operation hangs");
      finish_test();
    end
    @(negedge clk);
    chk(flag, 1'b1, "flag at completion");
  endtask : op
  task automatic t_write(input logic [6:0] r, input logic s);
    int ns;
    int np;
    ns = n_start;
    np = n_stop;
    rel = r;
    stretch = s;
    op(0, 8'h00, 1'b0, 1'b0);
    chk(8'(n_start - ns), 8'h01, "start seen");
    chk(scl, 1'b0, "clock held low");
    op(4, {SLV, 1'b0}, 1'b0, 1'b0);
    chk(ctrl[6], 1'b0, "write address ack");
    op(4, 8'ha5 ^ {1'b0, r}, 1'b0, 1'b1);
    chk(last, 8'ha5 ^ {1'b0, r}, "data byte");
    chk(ctrl[7], 1'b1, "refused write");
    chk(tl - tp >= 192 * (r + 1) && tl - tp <= 192 * (r + 2), 1'b1, "bit period");
    op(2, 8'h00, 1'b0, 1'b0);
    chk(8'(n_stop - np), 8'h01, "stop seen");
    chk({scl, sda}, 8'h03, "bus released");
    $display("test write reload %0d done", r);
  endtask : t_write
  task automatic t_read();
    rdb = 8'h96;
    op(0, 8'h00, 1'b0, 1'b0);
    op(4, {SLV, 1'b1}, 1'b0, 1'b0);
    chk(ctrl[6], 1'b0, "read address ack");
    op(3, 8'h00, 1'b0, 1'b0);
    chk(sbuf, 8'h96, "first read");
    chk(mack, 1'b0, "master ack");
    // Slave already drives bit 7, so keep it set
    rdb = 8'hd3;
    op(3, 8'h00, 1'b1, 1'b0);
    chk(sbuf, 8'hd3, "second read");
    chk(mack, 1'b1, "master nack");
    op(2, 8'h00, 1'b0, 1'b0);
    $display("test read done");
  endtask : t_read
  task automatic t_restart();
    int ns;
    int np;
    ns = n_start;
    np = n_stop;
    op(0, 8'h00, 1'b0, 1'b0);
    op(4, {~SLV, 1'b0}, 1'b0, 1'b0);
    chk(ctrl[6], 1'b1, "absent slave");
    op(1, 8'h00, 1'b0, 1'b0);
    chk(8'(n_start - ns), 8'h02, "repeated start");
    chk(8'(n_stop - np), 8'h00, "bus kept");
    op(4, {SLV, 1'b0}, 1'b0, 1'b0);
    chk(ctrl[6], 1'b0, "ack after restart");
    op(2, 8'h00, 1'b0, 1'b0);
    $display("test restart done");
  endtask : t_restart
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(posedge lclk);
    @(negedge clk);
    chk({busy, flag, scl_oe_n, sda_oe_n}, 8'h03, "idle after reset");
    chk(ctrl, 8'h00, "control after reset");
    chk(sbuf, 8'h00, "buffer after reset");
    $display("test reset done");
    t_write(7'h02, 1'b0);
    t_write(7'h05, 1'b1);
    t_read();
    t_restart();
    finish_test();
  end
endmodule : test_i2c_master_with_bit_rate_counter
`default_nettype wire
